// *** tac_ctrl.sv ***
`timescale 1ns/10ps
// Summary of operation
// [R1] pen mode bit reads current touch state
// [R2] mode write: 0 host, 1 touch; reset host
// [R3] state bit reads 0 busy, 1 done
// [R4] writing 0 runs scans until lift/stop
// [R5] writing 1 halts conversion, powers down converter
// [R6] state bit reads 1 after reset
// [R7] function field selects input, reads back
// [R8] one converter, result to matching register
// [R9] resolution field sets 12/8/10/12 bits, reads back
// [R10] resolution defaults to 12-bit code 00
// [R11] function 0 invalid, no update, reset value
// [R12] touch mode starts conversions on touch
module tac_ctrl
    import tac_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // touch panel
    input  wire logic        pen_down_flag,
    output logic [2:0]       drv_sel,
    // converter
    output logic             conv_power_on,
    output logic             conv_start,
    output logic             conv_abort,
    output logic [4:0]       conv_chan,
    output logic [3:0]       conv_bits,
    output logic [6:0]       conv_cfg,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    // result page write port
    output logic             result_wr,
    output logic [4:0]       result_idx,
    output logic [11:0]      result_data
);

    logic             rst_n;
    logic [9:0]       idx;
    logic             hit_ctrl;
    logic             hit_rsvd;
    logic             setup;
    logic             access;
    logic             ctl_wr;
    logic             wr_stop;
    logic [3:0]       wr_func;
    logic             wr_mode;
    logic [15:0]      ctrl_rd;
    logic [4:0]       dec_target;
    logic             dec_last;
    logic             dec_cont;
    logic [2:0]       dec_drv;
    logic             touch_go;

    logic             pen_touch_mode_q, pen_touch_mode_d;
    logic [3:0]       function_select_q, function_select_d;
    logic [1:0]       resolution_select_q, resolution_select_d;
    logic [6:0]       cfg_q, cfg_d;
    logic             run_q, run_d;
    logic             pend_q, pend_d;
    tac_state_t       state_q, state_d;
    logic [1:0]       step_q, step_d;
    logic [4:0]       chan_q, chan_d;
    logic [2:0]       drv_q, drv_d;
    logic             res_wr_q, res_wr_d;
    logic [4:0]       res_idx_q, res_idx_d;
    logic [11:0]      res_data_q, res_data_d;
    logic [31:0]      prdata_q, prdata_d;

    // reset release
    tac_rst_sync u_rst (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .rst_sync_n (rst_n)
    );

    // step decode of the selected function
    tac_func_decode u_dec (
        .func   (function_select_q),
        .step   (step_q),
        .target (dec_target),
        .last   (dec_last),
        .cont   (dec_cont),
        .drv    (dec_drv)
    );

    // address decode and bus phases
    assign idx      = paddr[11:2];
    assign hit_ctrl = (idx == TAC_IDX_CTRL);
    assign hit_rsvd = (idx == TAC_IDX_RSVD_0C) || (idx == TAC_IDX_RSVD_0D) || (idx == TAC_IDX_RSVD_0E) ||
                      (idx == TAC_IDX_RSVD_12) || (idx == TAC_IDX_RSVD_13) || (idx == TAC_IDX_RSVD_14) ||
                      (idx == TAC_IDX_RSVD_15) || (idx == TAC_IDX_RSVD_1B) || (idx == TAC_IDX_RSVD_1C) ||
                      (idx == TAC_IDX_RSVD_1D);
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign ctl_wr   = access && pwrite && hit_ctrl;
    assign wr_stop  = pwdata[TAC_BIT_CONV_STATE];
    assign wr_func  = pwdata[TAC_FUNC_HI:TAC_FUNC_LO];
    assign wr_mode  = pwdata[TAC_BIT_PEN_MODE];

    // zero wait states, error on unmapped words
    assign pready  = 1'b1;
    assign pslverr = access && !(hit_ctrl || hit_rsvd);
    assign prdata  = prdata_q;

    // control register readback
    always_comb begin
        ctrl_rd                               = 16'h0000;
        ctrl_rd[TAC_BIT_PEN_MODE]             = pen_down_flag; // [R1]
        ctrl_rd[TAC_BIT_CONV_STATE]           = (state_q == TAC_IDLE); // [R3] [R6]
        ctrl_rd[TAC_FUNC_HI:TAC_FUNC_LO]      = function_select_q; // [R7]
        ctrl_rd[TAC_RES_HI:TAC_RES_LO]        = resolution_select_q; // [R9]
        ctrl_rd[TAC_CFG_HI:TAC_CFG_LO]        = cfg_q;
    end

    // read data captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        if (setup && !pwrite) begin
            if (hit_ctrl) begin
                prdata_d = {16'h0000, ctrl_rd};
            end else if (hit_rsvd) begin
                prdata_d = {16'h0000, TAC_RSVD_VALUE};
            end else begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    // control fields written by software
    always_comb begin
        pen_touch_mode_d    = pen_touch_mode_q;
        function_select_d   = function_select_q;
        resolution_select_d = resolution_select_q;
        cfg_d               = cfg_q;
        run_d               = run_q;
        pend_d              = pend_q;
        if (ctl_wr) begin
            pen_touch_mode_d    = wr_mode; // [R2]
            function_select_d   = wr_func; // [R7]
            resolution_select_d = pwdata[TAC_RES_HI:TAC_RES_LO]; // [R9]
            cfg_d               = pwdata[TAC_CFG_HI:TAC_CFG_LO];
            run_d               = !wr_stop; // [R4] [R5]
            pend_d              = !wr_stop && !wr_mode && tac_is_conv(wr_func); // [R2] [R11]
        end else if (state_q == TAC_IDLE && pend_q) begin
            pend_d = 1'b0;
        end
    end

    // touch mode launches a scan on its own while the pen is down
    assign touch_go = pen_touch_mode_q && run_q && pen_down_flag && tac_is_touch(function_select_q); // [R12]

    // conversion sequencer
    always_comb begin
        state_d    = state_q;
        step_d     = step_q;
        chan_d     = chan_q;
        res_wr_d   = 1'b0;
        res_idx_d  = res_idx_q;
        res_data_d = res_data_q;
        case (state_q)
            TAC_IDLE: begin
                if (pend_q || touch_go) begin // [R11] [R12]
                    state_d = TAC_ISSUE;
                    step_d  = 2'h0;
                end
            end
            TAC_ISSUE: begin
                chan_d  = dec_target; // [R8]
                state_d = TAC_WAIT;
            end
            TAC_WAIT: begin
                if (conv_done) begin
                    res_wr_d   = 1'b1; // [R8]
                    res_idx_d  = chan_q;
                    res_data_d = conv_data;
                    if (!dec_last) begin
                        step_d  = step_q + 2'h1;
                        state_d = TAC_ISSUE;
                    end else if (dec_cont && run_q && pen_down_flag) begin
                        step_d  = 2'h0; // [R4]
                        state_d = TAC_ISSUE;
                    end else begin
                        state_d = TAC_IDLE;
                    end
                end
            end
            default: state_d = TAC_IDLE;
        endcase
        // any control write ends the running sequence at once
        if (ctl_wr) begin
            state_d = TAC_IDLE; // [R5]
            step_d  = 2'h0;
        end
    end

    // panel drivers follow driver-only functions until stopped
    always_comb begin
        drv_d = run_q ? dec_drv : 3'h0; // [R5]
    end

    // converter side outputs
    assign conv_start    = (state_q == TAC_ISSUE);
    assign conv_abort    = ctl_wr && (state_q != TAC_IDLE); // [R5]
    assign conv_power_on = (state_q != TAC_IDLE); // [R5]
    assign conv_chan     = chan_q;
    assign conv_bits     = tac_res_bits(resolution_select_q); // [R9]
    assign conv_cfg      = cfg_q;
    assign drv_sel       = drv_q;
    assign result_wr     = res_wr_q;
    assign result_idx    = res_idx_q;
    assign result_data   = res_data_q;

    // register all state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pen_touch_mode_q    <= TAC_RST_PEN_MODE; // [R2]
            function_select_q   <= TAC_RST_FUNC; // [R11]
            resolution_select_q <= TAC_RST_RES; // [R10]
            cfg_q               <= TAC_RST_CFG;
            run_q               <= 1'b1;
            pend_q              <= 1'b0;
            state_q             <= TAC_IDLE; // [R6]
            step_q              <= 2'h0;
            chan_q              <= 5'h00;
            drv_q               <= 3'h0;
            res_wr_q            <= 1'b0;
            res_idx_q           <= 5'h00;
            res_data_q          <= 12'h000;
            prdata_q            <= 32'h0000_0000;
        end else begin
            pen_touch_mode_q    <= pen_touch_mode_d;
            function_select_q   <= function_select_d;
            resolution_select_q <= resolution_select_d;
            cfg_q               <= cfg_d;
            run_q               <= run_d;
            pend_q              <= pend_d;
            state_q             <= state_d;
            step_q              <= step_d;
            chan_q              <= chan_d;
            drv_q               <= drv_d;
            res_wr_q            <= res_wr_d;
            res_idx_q           <= res_idx_d;
            res_data_q          <= res_data_d;
            prdata_q            <= prdata_d;
        end
    end

endmodule

// *** tac_pkg.sv ***
package tac_pkg;

    // register map: printed offsets are word indices, byte address is four times the index
    localparam int unsigned TAC_IDX_W            = 10;
    localparam logic [9:0]  TAC_IDX_CTRL         = 10'h000;
    localparam logic [9:0]  TAC_IDX_RSVD_0C      = 10'h00c;
    localparam logic [9:0]  TAC_IDX_RSVD_0D      = 10'h00d;
    localparam logic [9:0]  TAC_IDX_RSVD_0E      = 10'h00e;
    localparam logic [9:0]  TAC_IDX_RSVD_12      = 10'h012;
    localparam logic [9:0]  TAC_IDX_RSVD_13      = 10'h013;
    localparam logic [9:0]  TAC_IDX_RSVD_14      = 10'h014;
    localparam logic [9:0]  TAC_IDX_RSVD_15      = 10'h015;
    localparam logic [9:0]  TAC_IDX_RSVD_1B      = 10'h01b;
    localparam logic [9:0]  TAC_IDX_RSVD_1C      = 10'h01c;
    localparam logic [9:0]  TAC_IDX_RSVD_1D      = 10'h01d;
    localparam logic [15:0] TAC_RSVD_VALUE       = 16'hffff;

    // control register fields
    localparam int unsigned TAC_BIT_PEN_MODE     = 15;
    localparam int unsigned TAC_BIT_CONV_STATE   = 14;
    localparam int unsigned TAC_FUNC_HI          = 13;
    localparam int unsigned TAC_FUNC_LO          = 10;
    localparam int unsigned TAC_RES_HI           = 9;
    localparam int unsigned TAC_RES_LO           = 8;
    localparam int unsigned TAC_CFG_HI           = 7;
    localparam int unsigned TAC_CFG_LO           = 1;

    // reset values
    localparam logic        TAC_RST_PEN_MODE     = 1'b0;
    localparam logic [3:0]  TAC_RST_FUNC         = 4'h0;
    localparam logic [1:0]  TAC_RST_RES          = 2'h0;
    localparam logic [6:0]  TAC_RST_CFG          = 7'h00;

    // function select codes
    localparam logic [3:0]  TAC_FN_INVALID       = 4'h0;
    localparam logic [3:0]  TAC_FN_XY            = 4'h1;
    localparam logic [3:0]  TAC_FN_XYZ           = 4'h2;
    localparam logic [3:0]  TAC_FN_X             = 4'h3;
    localparam logic [3:0]  TAC_FN_Y             = 4'h4;
    localparam logic [3:0]  TAC_FN_Z             = 4'h5;
    localparam logic [3:0]  TAC_FN_BAT1          = 4'h6;
    localparam logic [3:0]  TAC_FN_BAT2          = 4'h7;
    localparam logic [3:0]  TAC_FN_AUX1          = 4'h8;
    localparam logic [3:0]  TAC_FN_AUX2          = 4'h9;
    localparam logic [3:0]  TAC_FN_TEMP1         = 4'ha;
    localparam logic [3:0]  TAC_FN_PORT          = 4'hb;
    localparam logic [3:0]  TAC_FN_TEMP2         = 4'hc;
    localparam logic [3:0]  TAC_FN_DRV_X         = 4'hd;
    localparam logic [3:0]  TAC_FN_DRV_Y         = 4'he;
    localparam logic [3:0]  TAC_FN_DRV_YX        = 4'hf;

    // result register indices on the data page
    localparam logic [4:0]  TAC_RES_X            = 5'h00;
    localparam logic [4:0]  TAC_RES_Y            = 5'h01;
    localparam logic [4:0]  TAC_RES_Z1           = 5'h02;
    localparam logic [4:0]  TAC_RES_Z2           = 5'h03;
    localparam logic [4:0]  TAC_RES_BAT1         = 5'h05;
    localparam logic [4:0]  TAC_RES_BAT2         = 5'h06;
    localparam logic [4:0]  TAC_RES_AUX1         = 5'h07;
    localparam logic [4:0]  TAC_RES_AUX2         = 5'h08;
    localparam logic [4:0]  TAC_RES_TEMP1        = 5'h09;
    localparam logic [4:0]  TAC_RES_TEMP2        = 5'h0a;

    // sequencer states
    typedef enum logic [1:0] {
        TAC_IDLE,
        TAC_ISSUE,
        TAC_WAIT
    } tac_state_t;

    // true when the function code runs conversions
    function automatic logic tac_is_conv(input logic [3:0] fn);
        tac_is_conv = (fn != TAC_FN_INVALID) && (fn < TAC_FN_DRV_X);
    endfunction

    // true when the function code is a touch screen scan
    function automatic logic tac_is_touch(input logic [3:0] fn);
        tac_is_touch = (fn >= TAC_FN_XY) && (fn <= TAC_FN_Z);
    endfunction

    // resolution code to number of result bits
    function automatic logic [3:0] tac_res_bits(input logic [1:0] rs);
        case (rs)
            2'h1:    tac_res_bits = 4'h8;
            2'h2:    tac_res_bits = 4'ha;
            default: tac_res_bits = 4'hc;
        endcase
    endfunction

endpackage

// *** tac_rst_sync.sv ***
`timescale 1ns/10ps
module tac_rst_sync
    import tac_pkg::*;
(
    // clock and raw reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // released reset
    output logic      rst_sync_n
);

    logic [1:0] sync_q;

    // asynchronous assert, two-stage release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_q <= 2'h0;
        end else begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end

    assign rst_sync_n = sync_q[1];

endmodule

// *** tac_func_decode.sv ***
`timescale 1ns/10ps
module tac_func_decode
    import tac_pkg::*;
(
    // selected function and step in its sequence
    input  wire logic [3:0] func,
    input  wire logic [1:0] step,
    // decoded step
    output logic [4:0]      target,
    output logic            last,
    output logic            cont,
    output logic [2:0]      drv
);

    logic [1:0] count;

    // maps each conversion function to its result registers in conversion order, and the driver-only functions to drv
    always_comb begin
        target = TAC_RES_X;
        count  = 2'h0;
        cont   = 1'b0;
        drv    = 3'h0;
        case (func)
            TAC_FN_XY: begin
                target = step[0] ? TAC_RES_Y : TAC_RES_X;
                count  = 2'h1;
                cont   = 1'b1;
            end
            TAC_FN_XYZ: begin
                target = {3'h0, step};
                count  = 2'h3;
                cont   = 1'b1;
            end
            TAC_FN_X:     target = TAC_RES_X;
            TAC_FN_Y:     target = TAC_RES_Y;
            TAC_FN_Z: begin
                target = step[0] ? TAC_RES_Z2 : TAC_RES_Z1;
                count  = 2'h1;
            end
            TAC_FN_BAT1:  target = TAC_RES_BAT1;
            TAC_FN_BAT2:  target = TAC_RES_BAT2;
            TAC_FN_AUX1:  target = TAC_RES_AUX1;
            TAC_FN_AUX2:  target = TAC_RES_AUX2;
            TAC_FN_TEMP1: target = TAC_RES_TEMP1;
            TAC_FN_PORT: begin
                target = TAC_RES_BAT1 + {3'h0, step};
                count  = 2'h3;
            end
            TAC_FN_TEMP2: target = TAC_RES_TEMP2;
            TAC_FN_DRV_X:  drv = 3'h1;
            TAC_FN_DRV_Y:  drv = 3'h2;
            TAC_FN_DRV_YX: drv = 3'h4;
            default: begin
                target = TAC_RES_X;
                count  = 2'h0;
            end
        endcase
        last = (step >= count);
    end

endmodule

// *** tac_ctrl_sva.sv ***
`timescale 1ns/10ps
module tac_ctrl_chk
    import tac_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // panel and converter
    input wire logic        pen_down_flag,
    input wire logic [2:0]  drv_sel,
    input wire logic        conv_power_on,
    input wire logic        conv_start,
    input wire logic        conv_abort,
    input wire logic [4:0]  conv_chan,
    input wire logic [3:0]  conv_bits,
    input wire logic [6:0]  conv_cfg,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    // result port
    input wire logic        result_wr,
    input wire logic [4:0]  result_idx,
    input wire logic [11:0] result_data
);
    // decoded apb access
    wire       acc   = psel && penable;
    wire [9:0] idx   = paddr[11:2];
    wire       rsv   = idx inside {TAC_IDX_RSVD_0C, TAC_IDX_RSVD_0D, TAC_IDX_RSVD_0E, TAC_IDX_RSVD_12,
                       TAC_IDX_RSVD_13, TAC_IDX_RSVD_14, TAC_IDX_RSVD_15, TAC_IDX_RSVD_1B,
                       TAC_IDX_RSVD_1C, TAC_IDX_RSVD_1D};
    wire       cwr   = acc && pwrite && idx == TAC_IDX_CTRL;
    wire [3:0] fn    = pwdata[13:10];
    function automatic logic [3:0] bits_of(input logic [1:0] rs);
        bits_of = (rs == 2'h1) ? 4'h8 : (rs == 2'h2) ? 4'ha : 4'hc;
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_run_wr;
        cwr && !pwdata[15] && !pwdata[14] && fn != 4'h0 && fn < 4'hd;
    endsequence
    sequence s_stop_wr;
        cwr && pwdata[14];
    endsequence
    apb_ready_a: assert property (acc |-> pready) else $error("pready low");
    map_err_a: assert property (acc |-> pslverr == !(rsv || idx == TAC_IDX_CTRL)) else $error("pslverr wrong");
    rsv_read_a: assert property (acc && !pwrite && rsv |-> prdata == 32'h0000ffff) else $error("reserved read");
    res_bits_a: assert property (cwr |=> conv_bits == bits_of($past(pwdata[9:8]))) else $error("bits");
    host_start_a: assert property (s_run_wr |-> ##[1:4] conv_start) else $error("no start");
    stop_quiet_a: assert property (s_stop_wr |=> (!conv_start && !conv_power_on)[*4]) else $error("no stop");
    inval_quiet_a: assert property (cwr && fn == 4'h0 |=> (!conv_start && !result_wr)[*4]) else $error("inval");
    result_src_a: assert property (result_wr |-> $past(conv_done) && result_idx == $past(conv_chan)
        && result_data == $past(conv_data)) else $error("result");
    start_busy_a: assert property (conv_start && !cwr |=> !conv_start && conv_power_on) else $error("start");
    drive_sel_a: assert property (cwr && fn == 4'hd && !pwdata[14] |-> ##[1:3] drv_sel == 3'h1) else $error("drv");
    abort_busy_a: assert property (cwr && conv_power_on |-> conv_abort) else $error("no abort");
    cfg_pass_a: assert property (cwr |=> conv_cfg == $past(pwdata[7:1])) else $error("cfg");
endmodule
bind tac_ctrl tac_ctrl_chk tac_ctrl_chk_i (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pen_down_flag, .drv_sel, .conv_power_on, .conv_start, .conv_abort, .conv_chan,
    .conv_bits, .conv_cfg, .conv_done, .conv_data, .result_wr, .result_idx, .result_data);

// *** tac_adc_model.sv ***
`timescale 1ns/10ps
module tac_adc_model
    import tac_pkg::*;
(
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rstn,
    // converter control
    input  wire logic   conv_start,
    input  wire logic   conv_abort,
    input  wire logic   conv_power_on,
    // result
    output logic        conv_done,
    output logic [11:0] conv_data
);
    int          seed_m;
    int          wait_q;
    logic [11:0] last_q;
    logic [11:0] dv;
    // one conversion at a time, dropped on abort or power down; data is junk when not valid
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seed_m = 4411;
            wait_q <= 0;
            conv_done <= 1'b0;
            last_q <= 12'h000;
            conv_data <= 12'hfff;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~last_q;
            dv = 12'($random(seed_m));
            if (conv_abort) wait_q <= 0;
            else if (conv_start) wait_q <= 3 + (dv[1:0]);
            else if (!conv_power_on) wait_q <= 0;
            else if (wait_q > 1) wait_q <= wait_q - 1;
            else if (wait_q == 1) begin
                wait_q <= 0;
                conv_done <= 1'b1;
                conv_data <= dv;
                last_q <= dv;
            end
        end
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top
    import tac_pkg::*;
;
    logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, pen_down_flag, err;
    logic        conv_power_on, conv_start, conv_abort, conv_done, result_wr;
    logic [11:0] paddr, conv_data, result_data;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  drv_sel;
    logic [4:0]  conv_chan, result_idx;
    logic [3:0]  conv_bits;
    logic [6:0]  conv_cfg;
    logic [15:0] wv;
    logic [19:0] ex;
    logic [4:0]  got_q[$];
    logic [9:0]  rsv[10] = '{TAC_IDX_RSVD_0C, TAC_IDX_RSVD_0D, TAC_IDX_RSVD_0E, TAC_IDX_RSVD_12,
                    TAC_IDX_RSVD_13, TAC_IDX_RSVD_14, TAC_IDX_RSVD_15, TAC_IDX_RSVD_1B, TAC_IDX_RSVD_1C,
                    TAC_IDX_RSVD_1D};
    int          bad_count, tests_run, seed;
    tac_ctrl tac_ctrl_i (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pen_down_flag, .drv_sel, .conv_power_on, .conv_start, .conv_abort, .conv_chan, .conv_bits,
        .conv_cfg, .conv_done, .conv_data, .result_wr, .result_idx, .result_data);
    tac_adc_model tac_adc_model_i (.core_clk, .rstn, .conv_start, .conv_abort, .conv_power_on, .conv_done,
        .conv_data);
    // result indices expected per function: count then up to four indices
    function automatic logic [19:0] exp_list(input logic [3:0] f);
        case (f)
            4'h1: exp_list = 20'h20100;
            4'h2: exp_list = 20'h40123;
            4'h3: exp_list = 20'h10000;
            4'h4: exp_list = 20'h11000;
            4'h5: exp_list = 20'h22300;
            4'hb: exp_list = 20'h45678;
            4'hc: exp_list = 20'h1a000;
            default: exp_list = {4'h1, f - 4'h1, 12'h000};
        endcase
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
        @(posedge core_clk);
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [32:0] exp);
        apb(1'b0, idx, 16'h0000);
        cmp({err, rd}, exp);
    endtask
    // wait for the converter power to reach a level, sampled at the falling edge
    task automatic wait_for(input logic lvl);
        int n;
        n = 0;
        while (conv_power_on !== lvl && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 2000) begin
            bad_count++;
            end_of_test();
        end
        @(posedge core_clk);
    endtask
    // free running clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // log every result write
    always @(posedge core_clk) begin
        if (result_wr === 1'b1) got_q.push_back(result_idx);
    end
    // main sequence
    initial begin
        {bad_count, tests_run, seed} = {32'd0, 32'd0, 32'd76089};
        {rstn, psel, penable, pwrite, pen_down_flag, paddr, pwdata} = '0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        rchk(TAC_IDX_CTRL, 33'h4000);
        foreach (rsv[i]) begin
            apb(1'b1, rsv[i], 16'($random(seed)));
            rchk(rsv[i], 33'h0ffff);
        end
        rchk(10'h001, {1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            wv = 16'($random(seed));
            wv[14] = 1'b1;
            wv[9:8] = i[1:0];
            apb(1'b1, TAC_IDX_CTRL, wv);
            cmp(33'(conv_bits), (i[1:0] == 2'h1) ? 33'h8 : (i[1:0] == 2'h2) ? 33'ha : 33'hc);
            rchk(TAC_IDX_CTRL, {19'h1, wv[13:1], 1'b0});
        end
        for (int f = 1; f <= 12; f++) begin
            got_q.delete();
            wv = {2'b00, 4'(f), 2'(f), 8'h00};
            apb(1'b1, TAC_IDX_CTRL, wv);
            wait_for(1'b1);
            rchk(TAC_IDX_CTRL, {19'h0, wv[13:8], 8'h0});
            wait_for(1'b0);
            rchk(TAC_IDX_CTRL, {19'h1, wv[13:8], 8'h0});
            ex = exp_list(4'(f));
            cmp(33'(got_q.size()), 33'(ex[19:16]));
            foreach (got_q[k]) if (k < 4) cmp(33'(got_q[k]), 33'(ex[15 - 4 * k -: 4]));
        end
        for (int f = 13; f <= 16; f++) begin
            got_q.delete();
            apb(1'b1, TAC_IDX_CTRL, {2'b00, 4'(f), 10'h000});
            repeat (8) @(posedge core_clk);
            cmp({drv_sel, conv_power_on, 29'(got_q.size())}, {3'(1 << (f - 13)), 30'h0});
        end
        apb(1'b1, TAC_IDX_CTRL, 16'h8400);
        repeat (10) @(posedge core_clk);
        cmp(33'(conv_power_on), 33'h0);
        got_q.delete();
        pen_down_flag <= 1'b1;
        wait_for(1'b1);
        rchk(TAC_IDX_CTRL, 33'h08400);
        repeat (60) @(posedge core_clk);
        pen_down_flag <= 1'b0;
        wait_for(1'b0);
        cmp(33'(got_q.size() > 4), 33'h1);
        cmp(33'(got_q[0] ^ got_q[1]), 33'h1);
        pen_down_flag <= 1'b1;
        wait_for(1'b1);
        apb(1'b1, TAC_IDX_CTRL, 16'hc400);
        got_q.delete();
        repeat (20) @(posedge core_clk);
        cmp({conv_power_on, 32'(got_q.size())}, 33'h0);
        rchk(TAC_IDX_CTRL, 33'h0c400);
        end_of_test();
    end
endmodule
